// [verif/cpmc_core_model.sv]
/*
 cpmc_core_model: stand-in for the core sequencer and interrupt sources beside cpmc_top.
 assumes the block's clk and rst; the bench sets irq_req as the enabled source level.
*/
`timescale 1ns/1ns
module cpmc_core_model (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic cpu_halt,
   input  wire logic cpu_reset,
   input  wire logic irq_req,
   output logic      instr_done,
   output logic      irq_pending
);
   logic [1:0] step_reg;
   // an instruction ends every fourth cycle, never when the core was held in the cycle before
   always_ff @(posedge clk) begin
      if (rst) begin
         step_reg   <= 2'h0;
         instr_done <= 1'b0;
      end else begin
         step_reg   <= step_reg + 2'h1;
         instr_done <= (step_reg == 2'h3) && !cpu_halt && !cpu_reset;
      end
   end
   assign irq_pending = irq_req;
endmodule

// [verif/cpu_power_mode_control_tb.sv]
/*
 cpu_power_mode_control_tb: self-checking bench for cpmc_top with a core model.
 assumes the 25 MHz clock, a small watchdog count and the fixed detector timeout.
*/
`timescale 1ns/1ns
module cpu_power_mode_control_tb
   import cpmc_pkg::*;
;
   localparam logic [TMR_W-1:0] WDG_SIM = 20'h00040;
   typedef struct {
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] d;
      logic [31:0] exp;
   } cpmc_row_s;
   // sel[0] low must be ignored; kick reads back 0; upper bits read 0
   cpmc_row_s rows [10] = '{
      '{8'h00, 4'hF, 32'h0, 32'h0}, '{8'h04, 4'hF, 32'h4, 32'h0},
      '{8'h08, 4'hF, 32'h1, 32'h1}, '{8'h08, 4'hE, 32'h0, 32'h1},
      '{8'h08, 4'hF, 32'h0, 32'h0}, '{8'h0C, 4'hF, 32'hFFFFFF00, 32'h0},
      '{8'h0C, 4'hF, 32'h1, 32'h1}, '{8'h10, 4'hF, 32'h0, 32'h0},
      '{8'h14, 4'hF, 32'hFF, 32'h0}, '{8'h18, 4'hF, 32'hFFFFFFFF, 32'h0}};
   logic        clk = 1'b0;
   logic        rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ack_done;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        instr_done, irq_pending, irq_req, ext_reset_n_pin, vbus_pin;
   logic        usb_activity_pin, cpu_halt, cpu_reset, wake_resume;
   logic        irq_gate_en, osc_run, periph_clk_en;
   logic [15:0] fetch_vector;
   int          n_errors, total_checks;

   always #20 clk = ~clk;

   cpmc_top #(.WDG_CYCLES(WDG_SIM)) DUT (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .instr_done, .irq_pending,
      .ext_reset_n_pin, .vbus_pin, .usb_activity_pin, .cpu_halt, .cpu_reset,
      .fetch_vector, .wake_resume, .irq_gate_en, .osc_run, .periph_clk_en);
   cpmc_core_model core (.clk, .rst, .cpu_halt, .cpu_reset, .irq_req, .instr_done,
      .irq_pending);

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic timed_out(input string what);
      n_errors++;
      $display("unexpected %s: expected done seen timeout", what);
      complete_run();
   endtask

   task automatic end_test(input string name);
      $display("test %s finished", name);
   endtask

   // the request holds until ack is sampled; instr_done at that edge is kept
   task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] d, output logic [31:0] rd);
      int i;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= d;
      for (i = 0; i < 10; i++) begin
         @(posedge clk);
         if (wb_ack_o === 1'b1)
            break;
      end
      if (i == 10)
         timed_out("wishbone ack");
      rd = wb_dat_o;
      ack_done = instr_done;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, adr, 4'hF, d, rd);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, adr, 4'hF, 32'h0, rd);
      check(what, rd, exp);
   endtask

   function automatic logic sigsel(input int k);
      case (k)
         1: return wake_resume;
         2: return cpu_reset;
         3: return !cpu_reset;
         default: return osc_run;
      endcase
   endfunction

   task automatic wait_sig(input int k, input int lim, output int n);
      n = 0;
      while (sigsel(k) !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > lim)
            timed_out("output wait");
      end
   endtask

   // halt must not rise before the writing instruction has ended
   task automatic enter_mode(input logic [31:0] d);
      logic seen;
      int   i;
      wr(OFF_POWER_CONTROL, d);
      seen = ack_done;
      #1;
      for (i = 0; i < 20 && !seen; i++) begin
         check("halt before instruction end", cpu_halt, 32'h0);
         @(posedge clk);
         seen = instr_done;
         #1;
      end
      check("halt after instruction end", cpu_halt, 32'h1);
   endtask

   initial begin
      int          n, k;
      logic [31:0] rd;
      rst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, irq_req, vbus_pin, usb_activity_pin} = 6'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
      ext_reset_n_pin = 1'b1;
      repeat (16) @(posedge clk);
      check("reset held", {cpu_halt, cpu_reset, wb_ack_o}, 32'h6);
      rst <= 1'b0;
      wait_sig(3, 12, n);
      check("fetch vector", fetch_vector, 32'h0);
      rd_chk("polarity reset", OFF_REGULATOR, 32'h1);
      rd_chk("power control reset", OFF_POWER_CONTROL, 32'h0);
      rd_chk("watchdog reset", OFF_WATCHDOG, 32'h0);
      rd_chk("status reset", OFF_STATUS, 32'h0);
      end_test("reset");
      foreach (rows[i]) begin
         bus(1'b1, rows[i].adr, rows[i].sel, rows[i].d, rd);
         rd_chk($sformatf("register %h", rows[i].adr), rows[i].adr, rows[i].exp);
      end
      end_test("registers");
      wr(OFF_WATCHDOG, 32'h0);
      enter_mode(32'h1);
      check("idle clocks", {osc_run, periph_clk_en, irq_gate_en}, 32'h7);
      rd_chk("idle state", OFF_STATUS, ST_IDLE);
      rd_chk("idle keeps register", OFF_REGULATOR, 32'h1);
      @(posedge clk);
      usb_activity_pin <= 1'b1;
      repeat (100) @(posedge clk);
      usb_activity_pin <= 1'b0;
      #1;
      check("idle without interrupt", {cpu_halt, cpu_reset}, 32'h2);
      @(posedge clk);
      irq_req <= 1'b1;
      wait_sig(1, 10, n);
      check("resume after wake", {cpu_halt, cpu_reset}, 32'h0);
      @(posedge clk);
      irq_req <= 1'b0;
      rd_chk("idle bit after wake", OFF_POWER_CONTROL, 32'h0);
      end_test("idle");
      wr(OFF_WATCHDOG, 32'h3);
      wr(OFF_WATCHDOG, 32'h0);
      rd_chk("watchdog locked", OFF_WATCHDOG, 32'h3);
      enter_mode(32'h1);
      wait_sig(2, int'(WDG_SIM) + 8, n);
      check("watchdog within count", 32'(n < int'(WDG_SIM)), 32'h1);
      wait_sig(3, 12, n);
      rd_chk("watchdog cause", OFF_STATUS, 32'(CAUSE_WDG) << ST_CAUSE_LSB);
      rd_chk("watchdog cleared", OFF_WATCHDOG, 32'h0);
      end_test("watchdog");
      enter_mode(32'h1);
      @(posedge clk);
      ext_reset_n_pin <= 1'b0;
      wait_sig(2, 10, n);
      check("pin reset vector", fetch_vector, 32'h0);
      @(posedge clk);
      ext_reset_n_pin <= 1'b1;
      wait_sig(3, 20, n);
      rd_chk("pin cause", OFF_STATUS, 32'(CAUSE_PIN) << ST_CAUSE_LSB);
      rd_chk("idle bit after pin", OFF_POWER_CONTROL, 32'h0);
      end_test("pin reset");
      wr(OFF_MISSING_CLOCK, 32'h1);
      @(posedge clk);
      irq_req <= 1'b1;
      enter_mode(32'h3);
      check("stop gates", {osc_run, periph_clk_en, irq_gate_en}, 32'h0);
      wait_sig(2, 3000, n);
      check("stop until detector", n, 32'(MCK_CYCLES));
      check("stop reset vector", fetch_vector, 32'h0);
      @(posedge clk);
      irq_req <= 1'b0;
      wait_sig(3, 12, n);
      rd_chk("detector cause", OFF_STATUS, 32'(CAUSE_MCK) << ST_CAUSE_LSB);
      rd_chk("detector cleared", OFF_MISSING_CLOCK, 32'h0);
      end_test("stop");
      for (k = 0; k < 2; k++) begin
         wr(OFF_REGULATOR, 32'(1 - k));
         wr(OFF_OSC_CONTROL, 32'h1);
         repeat (10) @(posedge clk);
         #1;
         check("suspend holds oscillator", {osc_run, cpu_halt}, 32'h1);
         @(posedge clk);
         if (k == 0)
            vbus_pin <= 1'b1;
         else
            usb_activity_pin <= 1'b1;
         wait_sig(4, 10, n);
         @(posedge clk);
         usb_activity_pin <= 1'b0;
         rd_chk("suspend cleared", OFF_OSC_CONTROL, 32'h0);
      end
      end_test("suspend");
      enter_mode(32'h1);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("reset mid-run", {cpu_halt, cpu_reset, osc_run, wake_resume}, 32'hE);
      wait_sig(3, 12, n);
      rd_chk("state after reset", OFF_STATUS, 32'h0);
      rd_chk("idle bit after reset", OFF_POWER_CONTROL, 32'h0);
      end_test("reset mid-run");
      complete_run();
   end
endmodule

// [verilog/cpmc_pkg.sv]
/*
 cpmc_pkg: constants, register map and state codes of the cpu power mode control block.
 assumes a single 25 MHz system clock and a classic wishbone register port.
*/
// Operation
// - idle waits for writing instruction to finish
// - idle keeps state, clocks, peripherals running
// - only enabled interrupt or reset ends idle
// - waking interrupt clears idle bit, restarts cpu
// - after handler, resume after idle instruction
// - reset ends idle, fetch from zero
// - enabled watchdog counts in idle, then resets
// - stop waits for writing instruction to finish
// - stop halts oscillator, cpu, digital peripherals
// - interrupts inactive while stopped
// - only reset ends stop, fetch from zero
// - missing clock detector resets out of stop
// - suspend holds oscillator until usb or vbus
package cpmc_pkg;

   localparam int CLK_HZ         = 25_000_000;
   localparam int MCK_TIMEOUT_US = 100;
   localparam int TMR_W          = 20;
   // a timeout: round down to whole cycles
   localparam logic [TMR_W-1:0] MCK_CYCLES =
      TMR_W'(MCK_TIMEOUT_US * (CLK_HZ / 1_000_000));
   localparam logic [TMR_W-1:0] RESET_HOLD_CYCLES = 20'h00004;

   localparam logic [15:0] RESET_VECTOR = 16'h0000;

   localparam logic [7:0] OFF_POWER_CONTROL = 8'h00;
   localparam logic [7:0] OFF_WATCHDOG      = 8'h04;
   localparam logic [7:0] OFF_MISSING_CLOCK = 8'h08;
   localparam logic [7:0] OFF_REGULATOR     = 8'h0C;
   localparam logic [7:0] OFF_OSC_CONTROL   = 8'h10;
   localparam logic [7:0] OFF_STATUS        = 8'h14;

   localparam int PC_IDLE_BIT  = 0;
   localparam int PC_STOP_BIT  = 1;
   localparam int WD_EN_BIT    = 0;
   localparam int WD_LOCK_BIT  = 1;
   localparam int WD_KICK_BIT  = 2;
   localparam int MCK_EN_BIT   = 0;
   localparam int VBSEL_BIT    = 0;
   localparam int OSC_SUSP_BIT = 0;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_CAUSE_LSB = 4;

   localparam logic WD_EN_RESET  = 1'b0;
   localparam logic MCK_EN_RESET = 1'b0;
   localparam logic VBSEL_RESET  = 1'b1;

   typedef enum logic [1:0] {
      CAUSE_POWER = 2'h0,
      CAUSE_PIN   = 2'h1,
      CAUSE_WDG   = 2'h2,
      CAUSE_MCK   = 2'h3
   } cpmc_cause_e;

   typedef enum logic [2:0] {
      ST_RUN   = 3'h0,
      ST_IDLE  = 3'h1,
      ST_STOP  = 3'h2,
      ST_SUSP  = 3'h3,
      ST_RESET = 3'h4
   } cpmc_state_e;

endpackage

// [verilog/cpmc_sync.sv]
/*
 cpmc_sync: two flip-flop synchroniser for asynchronous pins, one bit per lane.
 assumes the inputs are levels that stay put for several clock cycles.
*/
`timescale 1ns/1ns
module cpmc_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // meta_reg feeds q_reg and nothing else
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= INIT;
         q_reg    <= INIT;
      end else begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

   assign q = q_reg;

endmodule

// [verilog/cpmc_timer.sv]
/*
 cpmc_timer: up counter that pulses expire after limit running cycles, then wraps.
 assumes limit is at least one and stays constant while the counter runs.
*/
`timescale 1ns/1ns
module cpmc_timer
   import cpmc_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             restart,
   input  wire logic             run,
   input  wire logic [TMR_W-1:0] limit,
   output logic                  expire
);

   logic [TMR_W-1:0] cnt_reg;

   assign expire = run && !restart && (cnt_reg == limit - TMR_W'(1));

   always_ff @(posedge clk) begin
      if (rst || restart || expire) begin
         cnt_reg <= '0;
      end else if (run) begin
         cnt_reg <= cnt_reg + TMR_W'(1);
      end
   end

endmodule

// [verilog/cpmc_top.sv]
/*
 cpmc_top: idle, stop and oscillator suspend control with watchdog and missing clock reset.
 assumes instr_done and irq_pending come from core logic on clk; the three pins are
 asynchronous. clk itself is the always-on clock; osc_run and periph_clk_en gate the rest.
*/
`timescale 1ns/1ns
module cpmc_top
   import cpmc_pkg::*;
#(
   parameter logic [TMR_W-1:0] WDG_CYCLES = 20'h10000
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        instr_done,
   input  wire logic        irq_pending,
   input  wire logic        ext_reset_n_pin,
   input  wire logic        vbus_pin,
   input  wire logic        usb_activity_pin,
   output logic             cpu_halt,
   output logic             cpu_reset,
   output logic      [15:0] fetch_vector,
   output logic             wake_resume,
   output logic             irq_gate_en,
   output logic             osc_run,
   output logic             periph_clk_en
);

   cpmc_state_e      state_reg;
   cpmc_state_e      state_next;
   cpmc_cause_e      cause_reg;
   logic             ack_reg;
   logic [31:0]      rdata_reg;
   logic             pc_idle_reg;
   logic             pc_stop_reg;
   logic             wd_en_reg;
   logic             wd_lock_reg;
   logic             mck_en_reg;
   logic             vbsel_reg;
   logic             susp_reg;
   logic             wake_reg;
   logic [2:0]       pins_s;
   logic             ext_rst_s;
   logic             vbus_s;
   logic             usb_s;
   logic             wdg_exp;
   logic             mck_exp;
   logic             hold_exp;
   logic [TMR_W-1:0] mck_arm_reg;

   // bus decode
   wire        bus_req  = wb_cyc_i && wb_stb_i;
   wire        wr_en    = bus_req && wb_we_i && ack_reg && wb_sel_i[0];
   wire        sel_pc   = (wb_adr_i == OFF_POWER_CONTROL);
   wire        sel_wd   = (wb_adr_i == OFF_WATCHDOG);
   wire        sel_mck  = (wb_adr_i == OFF_MISSING_CLOCK);
   wire        sel_reg  = (wb_adr_i == OFF_REGULATOR);
   wire        sel_osc  = (wb_adr_i == OFF_OSC_CONTROL);
   wire        sel_st   = (wb_adr_i == OFF_STATUS);
   wire        wr_pc    = wr_en && sel_pc;
   wire        wr_wd    = wr_en && sel_wd;
   wire        wr_mck   = wr_en && sel_mck;
   wire        wr_reg   = wr_en && sel_reg;
   wire        wr_osc   = wr_en && sel_osc;

   wire [31:0] rd_pc    = {30'h0, pc_stop_reg, pc_idle_reg};
   wire [31:0] rd_wd    = {30'h0, wd_lock_reg, wd_en_reg};
   wire [31:0] rd_mck   = {31'h0, mck_en_reg};
   wire [31:0] rd_reg   = {31'h0, vbsel_reg};
   wire [31:0] rd_osc   = {31'h0, susp_reg};
   wire [31:0] rd_st    = {26'h0, cause_reg, 1'b0, state_reg};
   // unmapped offsets answer with zero and ignore writes
   wire [31:0] rd_word  = sel_pc  ? rd_pc  :
                          sel_wd  ? rd_wd  :
                          sel_mck ? rd_mck :
                          sel_reg ? rd_reg :
                          sel_osc ? rd_osc :
                          sel_st  ? rd_st  : 32'h0;

   // a write that completes on the same edge as instr_done still counts
   wire        eff_idle = wr_pc ? wb_dat_i[PC_IDLE_BIT] : pc_idle_reg;
   wire        eff_stop = wr_pc ? wb_dat_i[PC_STOP_BIT] : pc_stop_reg;
   wire        in_run   = (state_reg == ST_RUN);
   wire        in_idle  = (state_reg == ST_IDLE);
   wire        in_stop  = (state_reg == ST_STOP);
   wire        in_susp  = (state_reg == ST_SUSP);
   wire        in_reset = (state_reg == ST_RESET);

   wire        enter_stop = in_run && instr_done && eff_stop;
   wire        enter_idle = in_run && instr_done && eff_idle && !eff_stop;
   wire        enter_susp = in_run && wr_osc && wb_dat_i[OSC_SUSP_BIT] && !enter_stop && !enter_idle;
   wire        wake_irq   = in_idle && irq_pending;
   wire        susp_wake  = in_susp && (usb_s || (vbus_s == vbsel_reg));
   wire        wd_kick    = wr_wd && wb_dat_i[WD_KICK_BIT];
   // digital peripherals, the watchdog among them, freeze in stop and suspend
   wire        wd_run     = wd_en_reg && (in_run || in_idle);
   wire        mck_run    = mck_en_reg && in_stop;
   wire        trig       = ext_rst_s || wdg_exp || mck_exp;

   cpmc_sync #(
      .W    (3),
      .INIT (3'h1)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({usb_activity_pin, vbus_pin, ext_reset_n_pin}),
      .q   (pins_s)
   );

   assign ext_rst_s = !pins_s[0];
   assign vbus_s    = pins_s[1];
   assign usb_s     = pins_s[2];

   cpmc_timer u_wdg (
      .clk     (clk),
      .rst     (rst),
      .restart (wd_kick || !wd_en_reg),
      .run     (wd_run),
      .limit   (WDG_CYCLES),
      .expire  (wdg_exp)
   );

   cpmc_timer u_mck (
      .clk     (clk),
      .rst     (rst),
      .restart (!mck_run),
      .run     (mck_run),
      .limit   (MCK_CYCLES),
      .expire  (mck_exp)
   );

   // holds the core in reset for a fixed count, restarted while a source persists
   cpmc_timer u_hold (
      .clk     (clk),
      .rst     (rst),
      .restart (trig),
      .run     (in_reset),
      .limit   (RESET_HOLD_CYCLES),
      .expire  (hold_exp)
   );

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (enter_stop) begin
               state_next = ST_STOP;
            end else if (enter_idle) begin
               state_next = ST_IDLE;
            end else if (enter_susp) begin
               state_next = ST_SUSP;
            end
         end
         ST_IDLE: begin
            if (wake_irq) begin
               state_next = ST_RUN;
            end
         end
         ST_STOP: begin
            state_next = ST_STOP;
         end
         ST_SUSP: begin
            if (susp_wake) begin
               state_next = ST_RUN;
            end
         end
         ST_RESET: begin
            if (hold_exp) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RESET;
         end
      endcase
      if (trig) begin
         state_next = ST_RESET;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h0;
      end else begin
         ack_reg <= bus_req && !ack_reg;
         if (bus_req && !ack_reg) begin
            rdata_reg <= rd_word;
         end
      end
   end

   // any reset, internal ones included, returns the controls to their reset values
   always_ff @(posedge clk) begin
      if (rst || trig) begin
         pc_idle_reg <= 1'b0;
         pc_stop_reg <= 1'b0;
      end else begin
         if (wake_irq) begin
            pc_idle_reg <= 1'b0;
         end else if (wr_pc) begin
            pc_idle_reg <= wb_dat_i[PC_IDLE_BIT];
         end
         if (wr_pc) begin
            pc_stop_reg <= wb_dat_i[PC_STOP_BIT];
         end
      end
   end

   // once locked the watchdog can be armed but no longer disarmed
   always_ff @(posedge clk) begin
      if (rst || trig) begin
         wd_en_reg   <= WD_EN_RESET;
         wd_lock_reg <= 1'b0;
      end else if (wr_wd) begin
         wd_en_reg   <= wb_dat_i[WD_EN_BIT] || wd_lock_reg;
         wd_lock_reg <= wb_dat_i[WD_LOCK_BIT] || wd_lock_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || trig) begin
         mck_en_reg <= MCK_EN_RESET;
         vbsel_reg  <= VBSEL_RESET;
      end else begin
         if (wr_mck) begin
            mck_en_reg <= wb_dat_i[MCK_EN_BIT];
         end
         if (wr_reg) begin
            vbsel_reg <= wb_dat_i[VBSEL_BIT];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || trig || susp_wake) begin
         susp_reg <= 1'b0;
      end else if (enter_susp) begin
         susp_reg <= 1'b1;
      end
   end

   // the cause survives the reset it describes, so software can read it afterwards
   always_ff @(posedge clk) begin
      if (rst) begin
         cause_reg <= CAUSE_POWER;
      end else if (trig) begin
         cause_reg <= ext_rst_s ? CAUSE_PIN : (wdg_exp ? CAUSE_WDG : CAUSE_MCK);
      end
   end

   // no reset on interrupt wake: the core keeps its program counter
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= wake_irq && !trig;
      end
   end

   assign wb_ack_o      = ack_reg;
   assign wb_dat_o      = rdata_reg;
   assign cpu_halt      = !in_run;
   assign cpu_reset     = in_reset;
   assign fetch_vector  = RESET_VECTOR;
   assign wake_resume   = wake_reg;
   assign irq_gate_en   = !in_stop && !in_susp;
   // idle leaves every clock alone; registers simply see no new instructions
   assign osc_run       = !in_stop && !in_susp;
   assign periph_clk_en = !in_stop && !in_susp;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_idle_entry;
      $rose(state_reg == ST_IDLE) |-> $past(instr_done) && $past(pc_idle_reg || wr_pc);
   endproperty
   a_idle_entry: assert property (p_idle_entry) else $error("idle entered early");

   property p_idle_clocks;
      in_idle |-> osc_run && periph_clk_en && irq_gate_en && !cpu_reset;
   endproperty
   a_idle_clocks: assert property (p_idle_clocks) else $error("idle gated a clock");

   property p_idle_hold;
      in_idle && !irq_pending && !trig |=> in_idle;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle left without cause");

   property p_irq_wake;
      in_idle && irq_pending && !trig |=> in_run && !pc_idle_reg && wake_resume;
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake failed");

   property p_wake_no_reset;
      wake_resume |-> !cpu_reset ##1 !wake_resume;
   endproperty
   a_wake_no_reset: assert property (p_wake_no_reset) else $error("wake not clean");

   property p_reset_hold;
      trig |=> cpu_reset [*4];
   endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("reset hold too short");

   property p_wdg_reset;
      wdg_exp && !ext_rst_s |=> cpu_reset && cause_reg == CAUSE_WDG;
   endproperty
   a_wdg_reset: assert property (p_wdg_reset) else $error("watchdog reset lost");

   property p_stop_entry;
      $rose(state_reg == ST_STOP) |-> $past(instr_done);
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("stop entered early");

   property p_stop_halts;
      in_stop |-> !osc_run && !periph_clk_en && cpu_halt && !irq_gate_en;
   endproperty
   a_stop_halts: assert property (p_stop_halts) else $error("stop left a clock on");

   property p_stop_hold;
      in_stop && !trig |=> in_stop;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");

   always_ff @(posedge clk) begin
      if (rst || !mck_run) begin
         mck_arm_reg <= '0;
      end else begin
         mck_arm_reg <= mck_arm_reg + TMR_W'(1);
      end
   end

   property p_mck_stop;
      mck_run |-> mck_arm_reg < MCK_CYCLES;
   endproperty
   a_mck_stop: assert property (p_mck_stop) else $error("detector did not reset");

   property p_susp_hold;
      in_susp && !usb_s && (vbus_s != vbsel_reg) && !trig |=> in_susp;
   endproperty
   a_susp_hold: assert property (p_susp_hold) else $error("suspend woke early");

   property p_both_stop;
      in_run && instr_done && eff_stop && eff_idle && !trig |=> in_stop;
   endproperty
   a_both_stop: assert property (p_both_stop) else $error("both bits not stop");

   c_irq_wake: cover property (in_idle ##1 wake_resume);
   c_stop_mck: cover property (in_stop ##1 cpu_reset && cause_reg == CAUSE_MCK);
   c_susp_wake: cover property (in_susp ##1 in_run);
   c_wdg_idle: cover property (in_idle && wdg_exp);

endmodule
